/* File: lic_regs.sv */
`timescale 1ns/1ns
// ==========================================
// Line interface control and status registers
module lic_regs
(
  input wire logic mclk,
  input wire logic rst,
  // Host port request
  input wire lic_pkg::lic_host_req_t host_req,
  // Read data, one cycle after the read
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Line status inputs
  input wire logic [lic_pkg::NCH-1:0] signal_loss,
  input wire logic [lic_pkg::NCH-1:0] alarm_indication,
  input wire logic [lic_pkg::NCH-1:0] rail_select_pin,
  // Per-channel controls
  output logic [lic_pkg::NCH-1:0] tx_all_ones,
  output logic [lic_pkg::NCH-1:0] alarm_insert_on_loss,
  output logic [lic_pkg::NCH-1:0] driver_hiz,
  output logic [lic_pkg::NCH-1:0] single_rail,
  output logic [lic_pkg::NCH-1:0] ch_ami,
  output logic [lic_pkg::NCH-1:0] clock_recovery_on,
  output logic [lic_pkg::NCH-1:0] t1_shape,
  output lic_pkg::lic_tcode_t tx_template_code,
  // Global controls
  output lic_pkg::lic_glob_t glob,
  output logic bank_expanded
);
  // ==========================================
  // Storage
  logic [7:0] auto_all_ones; // All ones on loss enables
  logic [7:0] global_config; // Global settings
  logic [2:0] template_channel_index; // Template channel
  lic_pkg::lic_tcode_t tcode; // Template per channel
  logic [7:0] driver_tristate_cfg; // Driver high-Z
  logic [7:0] alarm_irq_mask; // Alarm interrupt mask
  logic [7:0] alarm_irq_flag; // Sticky change flags
  logic [7:0] bank_pointer; // Bank select
  logic [7:0] one_rail_force; // Force single rail
  logic [7:0] channel_line_code_select; // Per-channel AMI
  logic [7:0] clock_recovery_off; // Recovery disable
  // ==========================================
  // Decode
  logic is_exp; // Expanded bank selected
  logic wr_p; // Write to primary bank
  logic wr_e; // Write to expanded bank
  logic rd_ais; // Read of alarm status
  logic [7:0] ad; // Shorthand address
  logic [7:0] next_rd_data; // Read mux result
  logic [7:0] forced; // Single rail forced and recovery on

  // Only the exact code selects the expanded bank
  assign is_exp = (bank_pointer == lic_pkg::BANK_EXPANDED);
  assign ad = host_req.addr;
  assign wr_p = host_req.wr && !is_exp;
  assign wr_e = host_req.wr && is_exp;
  assign rd_ais = host_req.rd && !is_exp && (ad == lic_pkg::OFS_AIS);
  assign forced = one_rail_force & ~clock_recovery_off;

  // ==========================================
  // Bank pointer, same address in both banks
  always_ff @(posedge mclk)
  begin
    if (rst)
      bank_pointer <= lic_pkg::BANK_PRIMARY;
    else if (host_req.wr && (ad == lic_pkg::OFS_BANK))
      bank_pointer <= host_req.wdata;
  end

  // ==========================================
  // Primary bank writable registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      auto_all_ones <= lic_pkg::RST_VAL;
      global_config <= lic_pkg::RST_VAL;
      driver_tristate_cfg <= lic_pkg::RST_VAL;
      alarm_irq_mask <= lic_pkg::RST_VAL;
      template_channel_index <= lic_pkg::RST_VAL[2:0];
    end
    else if (wr_p)
    begin
      case (ad)
        lic_pkg::OFS_AUTO_ONES:
          auto_all_ones <= host_req.wdata;
        // Reserved top bit stays zero
        lic_pkg::OFS_GLOBAL:
          global_config <= host_req.wdata & lic_pkg::GCF_WMASK;
        // Upper index bits are not stored
        lic_pkg::OFS_TIDX:
          template_channel_index <= host_req.wdata[2:0];
        lic_pkg::OFS_DRV:
          driver_tristate_cfg <= host_req.wdata;
        lic_pkg::OFS_MASK:
          alarm_irq_mask <= host_req.wdata;
        default:
          ;
      endcase
    end
  end

  // ==========================================
  // Indirect template store, one code per channel
  always_ff @(posedge mclk)
  begin
    if (rst)
      tcode <= '0;
    else if (wr_p && (ad == lic_pkg::OFS_TSEL))
      tcode[template_channel_index] <=
        host_req.wdata[lic_pkg::TCODE_W-1:0];
  end

  // ==========================================
  // Expanded bank writable registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      one_rail_force <= lic_pkg::RST_VAL;
      channel_line_code_select <= lic_pkg::RST_VAL;
      clock_recovery_off <= lic_pkg::RST_VAL;
    end
    else if (wr_e)
    begin
      case (ad)
        lic_pkg::OFS_ONE_RAIL:
          one_rail_force <= host_req.wdata;
        lic_pkg::OFS_CH_CODE:
          channel_line_code_select <= host_req.wdata;
        lic_pkg::OFS_CRO:
          clock_recovery_off <= host_req.wdata;
        default:
          ;
      endcase
    end
  end

  // ==========================================
  // Alarm change flags, one cell per channel
  genvar ch;
  generate
    for (ch = 0; ch < lic_pkg::NCH; ch++)
    begin : g_alarm
      lic_alarm_cell u_cell
      (
        .mclk(mclk),
        .rst(rst),
        .status(alarm_indication[ch]),
        .mask(alarm_irq_mask[ch]),
        .clr(rd_ais),
        .flag(alarm_irq_flag[ch])
      );
    end
  endgenerate

  // ==========================================
  // Read mux; unmapped addresses read zero
  always_comb
  begin
    next_rd_data = 8'h00;
    if (ad == lic_pkg::OFS_BANK)
      next_rd_data = bank_pointer;
    else if (is_exp)
    begin
      case (ad)
        lic_pkg::OFS_ONE_RAIL: next_rd_data = one_rail_force;
        lic_pkg::OFS_CH_CODE: next_rd_data = channel_line_code_select;
        lic_pkg::OFS_CRO: next_rd_data = clock_recovery_off;
        default: next_rd_data = 8'h00;
      endcase
    end
    else
    begin
      case (ad)
        lic_pkg::OFS_LOSS: next_rd_data = signal_loss;
        lic_pkg::OFS_AUTO_ONES: next_rd_data = auto_all_ones;
        lic_pkg::OFS_GLOBAL: next_rd_data = global_config;
        lic_pkg::OFS_TIDX:
          next_rd_data = {5'h00, template_channel_index};
        // Indirect read of the indexed channel
        lic_pkg::OFS_TSEL:
          next_rd_data = {5'h00, tcode[template_channel_index]};
        lic_pkg::OFS_DRV: next_rd_data = driver_tristate_cfg;
        lic_pkg::OFS_AIS: next_rd_data = alarm_indication;
        lic_pkg::OFS_MASK: next_rd_data = alarm_irq_mask;
        lic_pkg::OFS_FLAG: next_rd_data = alarm_irq_flag;
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  // Registered read answer
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= host_req.rd;
      if (host_req.rd)
        rd_data <= next_rd_data;
    end
  end

  // ==========================================
  // Loss driven actions; one cycle behind the pins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_all_ones <= '0;
      alarm_insert_on_loss <= '0;
    end
    else
    begin
      tx_all_ones <= auto_all_ones & signal_loss;
      alarm_insert_on_loss <= signal_loss &
        {lic_pkg::NCH{global_config[lic_pkg::GCF_AIS_INS]}};
    end
  end

  // ==========================================
  // Per-channel line controls
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      driver_hiz <= '0;
      single_rail <= '0;
      ch_ami <= '0;
      clock_recovery_on <= '1;
    end
    else
    begin
      driver_hiz <= driver_tristate_cfg;
      clock_recovery_on <= ~clock_recovery_off;
      // Pin decides only where the force bit is clear
      single_rail <= forced | (~one_rail_force & rail_select_pin);
      // Per-channel code only counts when forced
      ch_ami <= (forced & channel_line_code_select) |
        (~forced & {lic_pkg::NCH{global_config[lic_pkg::GCF_AMI]}});
    end
  end

  // ==========================================
  // Template outputs; reserved codes pass through
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_template_code <= '0;
      t1_shape <= '0;
    end
    else
    begin
      tx_template_code <= tcode;
      for (int i = 0; i < lic_pkg::NCH; i++)
        t1_shape[i] <= (tcode[i] >= lic_pkg::TCODE_T1_MIN);
    end
  end

  // ==========================================
  // Global controls and bank flag
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      glob <= '0;
      glob.scp_on <= 1'b1;
      bank_expanded <= 1'b0;
    end
    else
    begin
      glob.scp_on <= !global_config[lic_pkg::GCF_SCP_OFF];
      glob.ami <= global_config[lic_pkg::GCF_AMI];
      glob.depth64 <= global_config[lic_pkg::GCF_DEPTH];
      glob.bw_high <= global_config[lic_pkg::GCF_BW];
      // Codes 00 and 10 leave the attenuator out
      glob.ja_tx <= (global_config[1:0] == lic_pkg::PLACE_TX);
      glob.ja_rx <= (global_config[1:0] == lic_pkg::PLACE_RX);
      bank_expanded <= is_exp;
    end
  end

  // ==========================================
  // Checks
  a_all_ones_loss:
    assert property (@(posedge mclk) disable iff (rst)
      ##1 tx_all_ones == ($past(auto_all_ones) & $past(signal_loss)))
    else $error("all ones output wrong");
  a_ais_insert:
    assert property (@(posedge mclk) disable iff (rst)
      !global_config[lic_pkg::GCF_AIS_INS] |=> alarm_insert_on_loss == '0)
    else $error("alarm inserted while disabled");
  a_placement_code:
    assert property (@(posedge mclk) disable iff (rst)
      global_config[0] == 1'b0 |=> !glob.ja_tx && !glob.ja_rx)
    else $error("attenuator not bypassed");
  // Any index read, not only one straight after a write
  a_index_high_zero:
    assert property (@(posedge mclk) disable iff (rst)
      host_req.rd && !is_exp && ad == lic_pkg::OFS_TIDX
      |=> rd_data[7:3] == 5'h00)
    else $error("index upper bits not zero");
  a_flag_read_clear:
    assert property (@(posedge mclk) disable iff (rst)
      rd_ais && $stable(alarm_indication) ##1 $stable(alarm_indication)
      |-> alarm_irq_flag == '0)
    else $error("flags not cleared by status read");
  a_bank_switch:
    assert property (@(posedge mclk) disable iff (rst)
      host_req.wr && ad == lic_pkg::OFS_BANK &&
      host_req.wdata == lic_pkg::BANK_EXPANDED |=> is_exp ##1 bank_expanded)
    else $error("bank switch not taken");
  a_force_rail:
    assert property (@(posedge mclk) disable iff (rst)
      forced != '0 |=> (single_rail & $past(forced)) == $past(forced))
    else $error("forced channel not single rail");
  a_driver_hiz:
    assert property (@(posedge mclk) disable iff (rst)
      $changed(driver_tristate_cfg) |=> driver_hiz == $past(driver_tristate_cfg))
    else $error("driver high-Z does not follow");
  // Status read answers with the live alarm pins
  a_status_read:
    assert property (@(posedge mclk) disable iff (rst)
      rd_ais |=> rd_valid && rd_data == $past(alarm_indication))
    else $error("alarm status read wrong");
  // Way home from either bank must always work
  a_bank_home:
    assert property (@(posedge mclk) disable iff (rst)
      host_req.wr && ad == lic_pkg::OFS_BANK &&
      host_req.wdata == lic_pkg::BANK_PRIMARY |=> !is_exp)
    else $error("bank pointer did not return to primary");
  // Protection off whenever asked for
  a_scp_follow:
    assert property (@(posedge mclk) disable iff (rst)
      global_config[lic_pkg::GCF_SCP_OFF] |=> !glob.scp_on)
    else $error("short protection left on when disabled");
  // Forced channels take their own line code
  a_code_forced:
    assert property (@(posedge mclk) disable iff (rst)
      forced != '0 |=>
      ((ch_ami ^ $past(channel_line_code_select)) & $past(forced)) == '0)
    else $error("per-channel code ignored while forced");
endmodule : lic_regs

/* File: lic_pkg.sv */
package lic_pkg;
  // ==========================================
  // Sizes
  localparam int NCH = 8;
  localparam int TCODE_W = 3;
  // ==========================================
  // Primary bank offsets
  localparam logic [7:0] OFS_LOSS = 8'h04;
  localparam logic [7:0] OFS_AUTO_ONES = 8'h0e;
  localparam logic [7:0] OFS_GLOBAL = 8'h0f;
  localparam logic [7:0] OFS_TIDX = 8'h10;
  localparam logic [7:0] OFS_TSEL = 8'h11;
  localparam logic [7:0] OFS_DRV = 8'h12;
  localparam logic [7:0] OFS_AIS = 8'h13;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_FLAG = 8'h15;
  localparam logic [7:0] OFS_BANK = 8'h1f;
  // Expanded bank offsets
  localparam logic [7:0] OFS_ONE_RAIL = 8'h00;
  localparam logic [7:0] OFS_CH_CODE = 8'h01;
  localparam logic [7:0] OFS_CRO = 8'h02;
  // ==========================================
  // Bank pointer codes
  localparam logic [7:0] BANK_PRIMARY = 8'h00;
  localparam logic [7:0] BANK_EXPANDED = 8'haa;
  // ==========================================
  // Global config fields
  localparam int GCF_AIS_INS = 6;
  localparam int GCF_SCP_OFF = 5;
  localparam int GCF_AMI = 4;
  localparam int GCF_DEPTH = 3;
  localparam int GCF_BW = 2;
  localparam logic [7:0] GCF_WMASK = 8'h7f;
  localparam logic [1:0] PLACE_TX = 2'h1;
  localparam logic [1:0] PLACE_RX = 2'h3;
  // Template codes
  localparam logic [2:0] TCODE_E1 = 3'h0;
  localparam logic [2:0] TCODE_T1_MIN = 3'h3;
  // Reset value of every writable register
  localparam logic [7:0] RST_VAL = 8'h00;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lic_host_req_t;
  typedef struct packed {
    logic scp_on;
    logic ami;
    logic depth64;
    logic bw_high;
    logic ja_tx;
    logic ja_rx;
  } lic_glob_t;
  typedef logic [NCH-1:0][TCODE_W-1:0] lic_tcode_t;
endpackage : lic_pkg

/* File: lic_alarm_cell.sv */
`timescale 1ns/1ns
// ==========================================
// One channel of alarm change detection
module lic_alarm_cell
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic status,
  input wire logic mask,
  input wire logic clr,
  output logic flag
);
  // Last seen status, for change detection
  logic prev;

  // Track status
  always_ff @(posedge mclk)
  begin
    if (rst)
      prev <= 1'b0;
    else
      prev <= status;
  end

  // Sticky flag; a change in the clearing cycle still sets it
  always_ff @(posedge mclk)
  begin
    if (rst)
      flag <= 1'b0;
    else if ((status != prev) && mask)
      flag <= 1'b1;
    else if (clr)
      flag <= 1'b0;
  end

  a_flag_set_on_change:
    assert property (@(posedge mclk) disable iff (rst)
      (status != prev) && mask |=> flag)
    else $error("alarm flag missed a masked change");
  a_flag_blocked_mask:
    assert property (@(posedge mclk) disable iff (rst)
      !flag && !mask |=> !flag)
    else $error("alarm flag set while masked");
endmodule : lic_alarm_cell

/* File: lic_host_model.sv */
`timescale 1ns/1ns
// ==========================================
// Host processor on the register port
module lic_host_model
(
  input wire logic mclk,
  output lic_pkg::lic_host_req_t host_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  // Idle port from time zero
  initial host_req = '0;
  // One-cycle write strobe, released bus is scrambled
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    host_req.wr <= 1'b1;
    host_req.addr <= a;
    host_req.wdata <= d;
    @(posedge mclk);
    host_req.wr <= 1'b0;
    host_req.addr <= ~a;
    host_req.wdata <= ~d;
  endtask : write
  // One-cycle read strobe, answer taken one cycle later
  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
    @(posedge mclk);
    host_req.rd <= 1'b1;
    host_req.addr <= a;
    @(posedge mclk);
    host_req.rd <= 1'b0;
    host_req.addr <= ~a;
    @(posedge mclk);
    ok = rd_valid;
    d = rd_data;
  endtask : read
endmodule : lic_host_model

/* File: lic_regs_bench.sv */
`timescale 1ns/1ns
// ==========================================
// Self-checking bench for the register group
module lic_regs_bench;
  logic mclk;
  logic rst;
  lic_pkg::lic_host_req_t host_req;
  logic [7:0] rd_data;
  logic rd_valid;
  // Line side stimulus
  logic [7:0] signal_loss;
  logic [7:0] alarm_indication;
  logic [7:0] rail_select_pin;
  // Observed controls
  logic [7:0] tx_all_ones;
  logic [7:0] alarm_insert_on_loss;
  logic [7:0] driver_hiz;
  logic [7:0] single_rail;
  logic [7:0] ch_ami;
  logic [7:0] clock_recovery_on;
  logic [7:0] t1_shape;
  lic_pkg::lic_tcode_t tx_template_code;
  lic_pkg::lic_glob_t glob;
  logic bank_expanded;
  int n_errors = 0;
  int tests_run = 0;
  logic [7:0] rv;
  logic ok;
  logic [7:0] gv[8] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h02,
                        8'h03, 8'hff};
  logic [7:0] rst_adr[8] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12,
                             8'h14, 8'h15, 8'h1f};

  lic_regs u_lic_regs (.mclk(mclk), .rst(rst), .host_req(host_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .signal_loss(signal_loss),
    .alarm_indication(alarm_indication),
    .rail_select_pin(rail_select_pin), .tx_all_ones(tx_all_ones),
    .alarm_insert_on_loss(alarm_insert_on_loss),
    .driver_hiz(driver_hiz), .single_rail(single_rail),
    .ch_ami(ch_ami), .clock_recovery_on(clock_recovery_on),
    .t1_shape(t1_shape), .tx_template_code(tx_template_code),
    .glob(glob), .bank_expanded(bank_expanded));
  lic_host_model u_lic_host_model (.mclk(mclk), .host_req(host_req),
    .rd_data(rd_data), .rd_valid(rd_valid));

  // ==========================================
  // Helpers
  // Single compare for every byte-wide result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Read and compare, valid flag included
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    u_lic_host_model.read(a, rv, ok);
    chk({7'h0, ok}, 8'h01);
    chk(rv, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_lic_host_model.write(a, d);
  endtask : wr
  // Outputs lag the register by one cycle
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle
  // Expected global struct, worked out bit by bit
  function automatic logic [7:0] gexp(input logic [7:0] g);
    return {2'h0, ~g[5], g[4], g[3], g[2], g[1:0] == 2'h1,
            g[1:0] == 2'h3};
  endfunction : gexp
  task automatic conclude();
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // ==========================================
  // Clock and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Whole run is well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    conclude();
  end

  // ==========================================
  // Test sequence
  initial
  begin
    rst = 1'b1;
    signal_loss = 8'h00;
    alarm_indication = 8'h00;
    rail_select_pin = 8'h00;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    #1;
    // Reset values, primary bank selected without host action
    chk({2'h0, glob}, 8'h20);
    chk(clock_recovery_on, 8'hff);
    chk({7'h0, bank_expanded}, 8'h00);
    foreach (rst_adr[i])
      rd(rst_adr[i], 8'h00);
    // All ones and alarm insert follow loss
    wr(8'h0e, 8'ha5);
    @(posedge mclk);
    signal_loss <= 8'h0f;
    settle();
    chk(tx_all_ones, 8'h05);
    chk(alarm_insert_on_loss, 8'h00);
    rd(8'h04, 8'h0f);
    wr(8'h0f, 8'h40);
    settle();
    chk(alarm_insert_on_loss, 8'h0f);
    // Every global field, reserved bit reads zero
    foreach (gv[i])
    begin
      wr(8'h0f, gv[i]);
      settle();
      chk({2'h0, glob}, gexp(gv[i]));
      rd(8'h0f, gv[i] & 8'h7f);
    end
    // Indirect templates, upper index bits ignored
    for (int ch = 0; ch < 8; ch++)
    begin
      wr(8'h10, 8'hf8 | 8'(ch));
      rd(8'h10, 8'(ch));
      wr(8'h11, 8'hf8 | 8'(ch));
    end
    for (int ch = 0; ch < 8; ch++)
    begin
      wr(8'h10, 8'(ch));
      rd(8'h10, 8'(ch));
      rd(8'h11, 8'(ch));
    end
    settle();
    for (int ch = 0; ch < 8; ch++)
      chk({5'h0, tx_template_code[ch]}, 8'(ch));
    chk(t1_shape, 8'hf8);
    // Driver high impedance per channel
    wr(8'h12, 8'h3c);
    settle();
    chk(driver_hiz, 8'h3c);
    // Alarm flags blocked by default mask
    @(posedge mclk);
    alarm_indication <= 8'h81;
    settle();
    rd(8'h15, 8'h00);
    wr(8'h13, 8'hff);
    rd(8'h13, 8'h81);
    wr(8'h14, 8'h0f);
    rd(8'h14, 8'h0f);
    // Bit 7 changes too but stays masked off
    @(posedge mclk);
    alarm_indication <= 8'h02;
    settle();
    rd(8'h15, 8'h03);
    rd(8'h13, 8'h02);
    rd(8'h15, 8'h00);
    rd(8'h07, 8'h00);
    // Expanded bank controls
    wr(8'h0f, 8'h10);
    wr(8'h1f, 8'haa);
    wr(8'h00, 8'h0f);
    wr(8'h01, 8'h05);
    wr(8'h02, 8'h01);
    @(posedge mclk);
    rail_select_pin <= 8'hf0;
    settle();
    chk({7'h0, bank_expanded}, 8'h01);
    chk(single_rail, 8'hfe);
    chk(ch_ami, 8'hf5);
    chk(clock_recovery_on, 8'hfe);
    rd(8'h00, 8'h0f);
    rd(8'h01, 8'h05);
    rd(8'h02, 8'h01);
    rd(8'h1f, 8'haa);
    wr(8'h1f, 8'h00);
    settle();
    chk({7'h0, bank_expanded}, 8'h00);
    rd(8'h00, 8'h00);
    // Second reset in mid-run, expanded bank left selected
    wr(8'h1f, 8'haa);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk({7'h0, bank_expanded}, 8'h00);
    rd(8'h0e, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h1f, 8'h00);
    chk(tx_all_ones, 8'h00);
    conclude();
  end
endmodule : lic_regs_bench
